/* File: rtl/bus_thr_pkg.sv */
// Constants, tables and carrier types for the bus voltage threshold bank
package bus_thr_pkg;
   localparam logic [7:0]  LV_OV_ADDR     = 8'hB9;
   localparam logic [7:0]  UV_ADDR        = 8'hBA;
   localparam logic [7:0]  REG_RESET      = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
   localparam int          WARN_LSB       = 0;
   localparam int          PROT_LSB       = 3;
   localparam int          FIELD_W        = 3;
   localparam int          DECODE_LAT     = 2;
   localparam int          PM_W           = 11;
   // Thresholds in tenths of a percent of bus target, so 82.5 % stays exact
   localparam logic [10:0] LV_OV_WARN_PM [8] = '{11'h47E, 11'h44C, 11'h4B0, 11'h4E2,
                                                11'h514, 11'h546, 11'h578, 11'h5AA};
   localparam logic [10:0] LV_OV_PROT_PM [8] = '{11'h5DC, 11'h578, 11'h514, 11'h640,
                                                11'h6A4, 11'h708, 11'h76C, 11'h7D0};
   localparam logic [10:0] LV_UV_WARN_PM [8] = '{11'h352, 11'h339, 11'h320, 11'h307,
                                                11'h2EE, 11'h2D5, 11'h36B, 11'h384};
   localparam logic [10:0] HV_UV_WARN_PM [8] = '{11'h2EE, 11'h2C6, 11'h29E, 11'h276,
                                                11'h244, 11'h21C, 11'h316, 11'h33E};

   typedef struct packed {
      logic [10:0] lv_ov_warn;
      logic [10:0] lv_ov_prot;
      logic [10:0] lv_uv_warn;
      logic [10:0] hv_uv_warn;
   } thresholds_t;

   typedef struct packed {
      logic lv_ov_warn;
      logic lv_uv_warn;
      logic hv_uv_warn;
   } warnings_t;

   localparam thresholds_t THR_RESET = '{lv_ov_warn: 11'h47E, lv_ov_prot: 11'h5DC,
                                         lv_uv_warn: 11'h352, hv_uv_warn: 11'h2EE};
endpackage : bus_thr_pkg

/* File: rtl/bus_voltage_threshold_regs.sv */
// Bus voltage threshold registers with decoded levels, warnings and protection fault
// Functional notes
// - Low bus overvoltage register, one byte read/write, top two bits reserved, resets zero.
// - Bits 2:0 pick low bus overvoltage warning 115,110,120..145 percent.
// - Bits 5:3 pick low bus overvoltage protection 150,140,130,160..200 percent.
// - Undervoltage register, one byte read/write, top two bits reserved, resets zero.
// - Bits 2:0 pick low bus undervoltage warning 85 down to 72.5, 87.5, 90.
// - Bits 5:3 pick high bus undervoltage warning 75 down to 54, 79, 83.
// - Protection crossing sets sticky fault bit and pulls fault alert output low.
`timescale 1ns/100ps
module bus_voltage_threshold_regs
(
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   input  wire logic [7:0]               reg_addr,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   input  wire logic [7:0]               reg_wdata,
   output logic      [7:0]               reg_rdata,
   input  wire logic [10:0]              lv_meas_pm,
   input  wire logic [10:0]              hv_meas_pm,
   input  wire logic                     fault_clear,
   output bus_thr_pkg::thresholds_t      thr,
   output bus_thr_pkg::warnings_t        warn,
   output logic                          lv_ov_fault,
   output logic                          fault_alert_n
);
   import bus_thr_pkg::*;

   logic [7:0]  lv_ov_r;
   logic [7:0]  uv_r;
   logic [7:0]  rdata_r;
   thresholds_t thr_r;
   warnings_t   warn_r;
   logic        fault_r;
   logic        alert_n_r;

   // Measurements arrive from the converter on this clock, so no synchroniser
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lv_ov_r <= REG_RESET;
         uv_r    <= REG_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == LV_OV_ADDR)
            lv_ov_r <= reg_wdata;
         if (reg_addr == UV_ADDR)
            uv_r <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         rdata_r <= UNMAPPED_READ;
      else if (reg_rd)
      begin
         case (reg_addr)
            LV_OV_ADDR: rdata_r <= lv_ov_r;
            UV_ADDR:    rdata_r <= uv_r;
            default:    rdata_r <= UNMAPPED_READ;
         endcase
      end
   end

   // Decoding is registered so the comparators see a settled table value
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         thr_r <= THR_RESET;
      else
      begin
         thr_r.lv_ov_warn <= LV_OV_WARN_PM[lv_ov_r[WARN_LSB +: FIELD_W]];
         thr_r.lv_ov_prot <= LV_OV_PROT_PM[lv_ov_r[PROT_LSB +: FIELD_W]];
         thr_r.lv_uv_warn <= LV_UV_WARN_PM[uv_r[WARN_LSB +: FIELD_W]];
         thr_r.hv_uv_warn <= HV_UV_WARN_PM[uv_r[PROT_LSB +: FIELD_W]];
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         warn_r <= '0;
      else
      begin
         warn_r.lv_ov_warn <= (lv_meas_pm > thr_r.lv_ov_warn);
         warn_r.lv_uv_warn <= (lv_meas_pm < thr_r.lv_uv_warn);
         warn_r.hv_uv_warn <= (hv_meas_pm < thr_r.hv_uv_warn);
      end
   end

   // A crossing in the same cycle as a clear keeps the fault set
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         fault_r <= 1'b0;
      else if (lv_meas_pm > thr_r.lv_ov_prot)
         fault_r <= 1'b1;
      else if (fault_clear)
         fault_r <= 1'b0;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         alert_n_r <= 1'b1;
      else
         alert_n_r <= ~fault_r;
   end

   assign reg_rdata     = rdata_r;
   assign thr           = thr_r;
   assign warn          = warn_r;
   assign lv_ov_fault   = fault_r;
   assign fault_alert_n = alert_n_r;

   AST_LV_OV_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == LV_OV_ADDR) |=> (lv_ov_r == $past(reg_wdata)))
      else $error("low bus overvoltage register did not take write");

   AST_UV_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !(reg_wr && reg_addr == UV_ADDR) |=> $stable(uv_r))
      else $error("undervoltage register changed without a write");

   AST_RD_ANSWER: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_rd && reg_addr == LV_OV_ADDR && !reg_wr) |=> (reg_rdata == lv_ov_r))
      else $error("read of low bus overvoltage register wrong");

   AST_LV_OV_WARN_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == LV_OV_ADDR) |=> ##1
      (thr.lv_ov_warn == LV_OV_WARN_PM[$past(reg_wdata[WARN_LSB +: FIELD_W], DECODE_LAT)]))
      else $error("overvoltage warning decode wrong");

   AST_LV_OV_PROT_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == LV_OV_ADDR) |=> ##1
      (thr.lv_ov_prot == LV_OV_PROT_PM[$past(reg_wdata[PROT_LSB +: FIELD_W], DECODE_LAT)]))
      else $error("overvoltage protection decode wrong");

   AST_LV_UV_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == UV_ADDR) |=> ##1
      (thr.lv_uv_warn == LV_UV_WARN_PM[$past(reg_wdata[WARN_LSB +: FIELD_W], DECODE_LAT)]))
      else $error("low bus undervoltage decode wrong");

   AST_HV_UV_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == UV_ADDR) |=> ##1
      (thr.hv_uv_warn == HV_UV_WARN_PM[$past(reg_wdata[PROT_LSB +: FIELD_W], DECODE_LAT)]))
      else $error("high bus undervoltage decode wrong");

   AST_FAULT_ALERT: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (lv_meas_pm > thr.lv_ov_prot) |=> lv_ov_fault ##1 !fault_alert_n)
      else $error("protection crossing did not raise fault and alert");

   AST_FAULT_STICKY: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (lv_ov_fault && !fault_clear) |=> lv_ov_fault)
      else $error("fault dropped without clear");

   AST_UV_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == UV_ADDR) |=> (uv_r == $past(reg_wdata)))
      else $error("undervoltage register did not take write");

   AST_LV_OV_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !(reg_wr && reg_addr == LV_OV_ADDR) |=> $stable(lv_ov_r))
      else $error("low bus overvoltage register changed without a write");

   // Writes to any other command code must leave both bytes alone
   AST_UNMAPPED_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr != LV_OV_ADDR && reg_addr != UV_ADDR) |=> ($stable(lv_ov_r) && $stable(uv_r)))
      else $error("write to unmapped code changed a register");

   AST_RD_UV_ANSWER: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_rd && reg_addr == UV_ADDR && !reg_wr) |=> (reg_rdata == uv_r))
      else $error("read of undervoltage register wrong");

   AST_RD_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (reg_rd && reg_addr != LV_OV_ADDR && reg_addr != UV_ADDR) |=> (reg_rdata == UNMAPPED_READ))
      else $error("read of unmapped code not zero");

   // Read data is held so a slow controller can fetch it late
   AST_RD_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   AST_THR_STABLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !reg_wr |=> ##1 $stable(thr))
      else $error("thresholds moved without a write");

   AST_LV_OV_WARN_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (lv_meas_pm > thr.lv_ov_warn) |=> warn.lv_ov_warn)
      else $error("low bus overvoltage warning missed");

   AST_LV_OV_WARN_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (lv_meas_pm <= thr.lv_ov_warn) |=> !warn.lv_ov_warn)
      else $error("low bus overvoltage warning raised below threshold");

   AST_LV_UV_WARN_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (lv_meas_pm < thr.lv_uv_warn) |=> warn.lv_uv_warn)
      else $error("low bus undervoltage warning missed");

   AST_LV_UV_WARN_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (lv_meas_pm >= thr.lv_uv_warn) |=> !warn.lv_uv_warn)
      else $error("low bus undervoltage warning raised above threshold");

   AST_HV_UV_WARN_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (hv_meas_pm < thr.hv_uv_warn) |=> warn.hv_uv_warn)
      else $error("high bus undervoltage warning missed");

   AST_HV_UV_WARN_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (hv_meas_pm >= thr.hv_uv_warn) |=> !warn.hv_uv_warn)
      else $error("high bus undervoltage warning raised above threshold");

   AST_FAULT_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (lv_ov_fault && fault_clear && !(lv_meas_pm > thr.lv_ov_prot)) |=> !lv_ov_fault)
      else $error("fault not cleared");

   AST_FAULT_NEEDS_CROSSING: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!lv_ov_fault && !(lv_meas_pm > thr.lv_ov_prot)) |=> !lv_ov_fault)
      else $error("fault raised without a crossing");

   AST_ALERT_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
      lv_ov_fault |=> !fault_alert_n)
      else $error("fault alert output not low while fault stands");

   AST_ALERT_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !lv_ov_fault |=> fault_alert_n)
      else $error("fault alert output low without fault");
endmodule : bus_voltage_threshold_regs

/* File: tb/sys_ctrl_model.sv */
// System controller model issuing single byte register commands
`timescale 1ns/100ps
module sys_ctrl_model
(
   input  wire logic sys_clk,
   output logic [7:0] reg_addr,
   output logic       reg_wr,
   output logic       reg_rd,
   output logic [7:0] reg_wdata
);
   initial
   begin
      {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
   end
   // Strobe lasts one edge; data inverted after so a stale byte never looks valid
   task op(input logic w, input logic [7:0] a, input logic [7:0] d);
   begin
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= w;
      reg_rd    <= !w;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_wdata <= ~d;
   end
   endtask : op
endmodule : sys_ctrl_model

/* File: tb/bus_voltage_threshold_regs_bench.sv */
// Self-checking bench for the bus voltage threshold bank
`timescale 1ns/100ps
module bus_voltage_threshold_regs_bench;
   import bus_thr_pkg::*;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, b;
   logic        reg_wr, reg_rd, lv_ov_fault, fault_alert_n;
   logic        rd_d = 1'b0;
   logic        fault_clear = 1'b0;
   logic [10:0] lv_meas_pm = 11'h3E8;
   logic [10:0] hv_meas_pm = 11'h3E8;
   thresholds_t thr;
   warnings_t   warn;
   logic [31:0] rng = 32'h5BE33AEA;
   logic [7:0]  exp_q[$];
   int          error_cnt = 0;
   int          checks = 0;
   always #20 sys_clk = ~sys_clk;
   sys_ctrl_model sys_ctrl_model_inst (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
   bus_voltage_threshold_regs bus_voltage_threshold_regs_inst (.sys_clk, .reset_n, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .lv_meas_pm, .hv_meas_pm, .fault_clear, .thr, .warn, .lv_ov_fault,
      .fault_alert_n);
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic chk(input logic [43:0] got, input logic [43:0] exp);
   begin
      #1;
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask : chk
   // Reads note their expected byte; the monitor below pops it when data lands
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
   begin
      @(posedge sys_clk);
      if (!w)
         exp_q.push_back(d);
      sys_ctrl_model_inst.op(w, a, d);
   end
   endtask : acc
   task give_verdict;
   begin
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask : give_verdict
   always @(posedge sys_clk) rd_d <= reg_rd;
   always @(negedge sys_clk)
      if (rd_d === 1'b1)
         chk(reg_rdata, exp_q.pop_front());
   initial
   begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      chk(thr, THR_RESET);
      acc(0, LV_OV_ADDR, REG_RESET);
      acc(0, UV_ADDR, REG_RESET);
      for (int i = 0; i < 8; i++)
      begin
         rng = xs(rng);
         b = {rng[7:6], i[2:0], 3'(7 - i)};
         acc(1, LV_OV_ADDR, b);
         acc(1, UV_ADDR, ~b);
         acc(0, LV_OV_ADDR, b);
         acc(0, UV_ADDR, ~b);
         chk(thr, {LV_OV_WARN_PM[7-i], LV_OV_PROT_PM[i], LV_UV_WARN_PM[i], HV_UV_WARN_PM[7-i]});
      end
      acc(1, 8'hBB, 8'hFF);
      acc(0, 8'hBB, UNMAPPED_READ);
      acc(0, LV_OV_ADDR, b);
      @(posedge sys_clk);
      lv_meas_pm <= 11'h7D1 + 11'(rng[12:8]);
      repeat (3) @(posedge sys_clk);
      chk({lv_ov_fault, fault_alert_n, warn}, 5'b10100);
      @(posedge sys_clk);
      fault_clear <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(lv_ov_fault, 1'b1);
      @(posedge sys_clk);
      lv_meas_pm <= 11'h320;
      hv_meas_pm <= 11'h2BC;
      repeat (3) @(posedge sys_clk);
      chk({lv_ov_fault, fault_alert_n, warn}, 5'b01011);
      @(posedge sys_clk);
      lv_meas_pm <= 11'h3E8;
      hv_meas_pm <= 11'h3E8;
      repeat (3) @(posedge sys_clk);
      chk({lv_ov_fault, fault_alert_n, warn}, 5'b01000);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      acc(0, LV_OV_ADDR, REG_RESET);
      acc(0, UV_ADDR, REG_RESET);
      repeat (2) @(posedge sys_clk);
      chk(thr, THR_RESET);
      give_verdict;
   end
   initial
   begin
      #200000;
      error_cnt++;
      give_verdict;
   end
endmodule : bus_voltage_threshold_regs_bench
